// ==== dfc_chk.sv ====
// ********
// link and alert checker
// ********
module dfc_chk
(
  // clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // serial link
  input wire logic sclk,
  input wire logic sdin,
  input wire logic latchN,
  // alert wire and its causes
  input wire logic alertOut,
  input wire logic alertOe,
  input wire logic headroomLow,
  input wire logic overTemp
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_b);
  // the device only ever sinks the shared wire
  AST_OPEN_DRAIN: assert property (alertOe |-> !alertOut)
    else $error("alert wire driven high");
  // six samples cover the two sync stages and the output flop
  AST_ALERT_SET: assert property (
    (headroomLow || overTemp)[*6] |-> alertOe)
    else $error("alert not raised");
  AST_ALERT_FREE: assert property (
    (!headroomLow && !overTemp)[*6] |-> !alertOe)
    else $error("alert not released");
  // the serial clock must never be high outside a frame
  AST_SCLK_FRAMED: assert property (sclk |-> !latchN)
    else $error("serial clock outside frame");
  AST_SDIN_STABLE: assert property (sclk |-> $stable(sdin))
    else $error("data moved while clock high");
  AST_SCLK_HIGH: assert property (
    $rose(sclk) |-> sclk[*8] ##1 !sclk)
    else $error("clock high phase wrong");
  AST_STROBE_LOW: assert property ($fell(latchN) |-> !latchN[*8])
    else $error("load strobe too short");
  AST_STROBE_GAP: assert property ($rose(latchN) |-> latchN[*8])
    else $error("gap after strobe too short");
  // main scenarios
  cover property ($rose(alertOe));
  cover property ($fell(latchN) ##1 (!sclk && !latchN)[*6]);
  cover property ($rose(sclk) && !latchN);
endmodule : dfc_chk

// ==== dfc_device.sv ====
// Summary of operation
// - alert is open-drain, shareable wired line
// - alert on current output headroom loss
// - alert on die over temperature
// - separate status flags name alert cause
// - extend bit widens voltage range tenfold-percent
// - clear pin high forces clear value
// - clear level is pin OR control bit
// - level 0: 0 V; 1: mid/zero scale
// - clear puts current at range bottom
// - host holds clear for minimum width
// - cleared value stays after clear release
// - bare load pulse restores previous value
// - no new value accepted while clearing
// - range change loads default value
// - host disables output before range change
// - enabling output loads default value
// - control bit selects outside resistor
// - modem coupling only while output enabled
// - host enables slew limit for modem
// - outputs off unless enabled; range picks
// - status word is read only
//
// The register addresses and the APB register port were left to the implementer.
module dfc_device
  import dfc_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // link to the host
  dfc_link_if.device link,
  // analog sense levels, asynchronous
  input wire logic headroomLow,
  input wire logic overTemp,
  input wire logic slewBusy,
  // converter controls
  output logic [15:0] dacCode,
  output logic [2:0] rangeSel,
  output logic voltEnable,
  output logic currEnable,
  output logic modemCouplingEnable,
  output logic rangeExtend,
  output logic outsideResistorSelect,
  // slew engine settings
  output logic slewEnable,
  output logic [3:0] slewClock,
  output logic [2:0] slewStep,
  output logic chainEnable
);
  // ************************************************
  // state
  // ************************************************
  typedef struct packed {
    logic sclkPrev; // last synced serial clock
    logic latchPrev; // last synced load strobe
    logic [FRAME_BITS-1:0] shift; // incoming frame
    logic [CNT_W-1:0] bitCnt; // bits since strobe fell
    logic [15:0] ctrl; // control word
    logic [15:0] dataReg; // last accepted value
    logic [15:0] code; // code driven to converter
    logic [15:0] sdoShift; // readback shifter
    logic voltEn; // voltage output live
    logic currEn; // current output live
    logic alertOe; // pulling the alert wire
    logic [2:0] status; // fault, slew, temperature
  } dfc_dev_s;

  dfc_dev_s q; // registered state
  dfc_dev_s n; // next state
  logic [7:0] syncOut; // synchronised pins and sense
  logic sclkS; // serial clock
  logic sdinS; // serial data
  logic latchS; // load strobe, low active level
  logic clearS; // clear request
  logic clearSelS; // clear select pin
  logic headroomS; // headroom fault
  logic overTempS; // temperature fault
  logic slewS; // slew busy
  logic sclkRise; // serial clock edge
  logic latchRise; // end of frame or bare pulse
  logic latchFall; // start of frame
  logic effSel; // effective clear level
  logic [7:0] frameAddr; // address byte of frame
  logic [15:0] frameData; // data word of frame
  logic [2:0] newRange; // range in an incoming control word
  logic [2:0] curRange; // range in force

  // ************************************************
  // input synchronisers
  // ************************************************
  // every pin is asynchronous to clock; the strobe idles high
  dfc_sync #(
    .WIDTH(8),
    .INIT(8'h04)
  ) uSync (
    .clock(clock),
    .rst_b(rst_b),
    .async({slewBusy, overTemp, headroomLow, link.clearSelPin,
      link.clearPin, link.latchN, link.sdin, link.sclk}),
    .sync(syncOut)
  );

  assign sclkS = syncOut[0];
  assign sdinS = syncOut[1];
  assign latchS = syncOut[2];
  assign clearS = syncOut[3];
  assign clearSelS = syncOut[4];
  assign headroomS = syncOut[5];
  assign overTempS = syncOut[6];
  assign slewS = syncOut[7];

  assign sclkRise = sclkS & ~q.sclkPrev;
  assign latchRise = latchS & ~q.latchPrev;
  assign latchFall = ~latchS & q.latchPrev;
  assign frameAddr = q.shift[FRAME_BITS-1:16];
  assign frameData = q.shift[15:0];
  assign newRange = frameData[CTRL_RANGE_HI:CTRL_RANGE_LO];
  assign curRange = q.ctrl[CTRL_RANGE_HI:CTRL_RANGE_LO];
  assign effSel = clearSelS | q.ctrl[CTRL_CLEAR_LEVEL];

  // ************************************************
  // next state
  // ************************************************
  // one process decodes frames, clear and faults in priority order:
  // frame decode first, then clear overrides the code it produced
  always_comb
  begin
    n = q;
    n.sclkPrev = sclkS;
    n.latchPrev = latchS;
    // shift in only inside a frame, so stray clocks are harmless
    if (sclkRise && !latchS)
    begin
      n.shift = {q.shift[FRAME_BITS-2:0], sdinS};
      n.sdoShift = {q.sdoShift[14:0], 1'b0};
      if (q.bitCnt != CNT_W'(FRAME_BITS))
      begin
        n.bitCnt = q.bitCnt + CNT_W'(1);
      end
    end
    // strobe falling opens a new frame
    if (latchFall)
    begin
      n.bitCnt = '0;
    end
    // strobe rising acts on what was shifted
    if (latchRise)
    begin
      if (q.bitCnt == '0)
      begin
        // bare pulse: bring back the pre-clear value
        if (!clearS)
        begin
          n.code = q.dataReg;
        end
      end
      else if (q.bitCnt == CNT_W'(FRAME_BITS))
      begin
        case (frameAddr)
          ADDR_DATA:
          begin
            // value writes are dropped during a clear
            if (!clearS)
            begin
              n.dataReg = frameData;
              n.code = frameData;
            end
          end
          ADDR_CTRL:
          begin
            n.ctrl = frameData;
            // range change or enable rising loads the default
            if ((newRange != curRange)
              || (frameData[CTRL_DRIVE_EN]
              && !q.ctrl[CTRL_DRIVE_EN]))
            begin
              n.code = dfc_default_code(newRange,
                clearSelS | frameData[CTRL_CLEAR_LEVEL]);
              n.dataReg = n.code;
            end
          end
          ADDR_READ:
          begin
            // status goes out MSB first on the next frame
            n.sdoShift = {13'h0, q.status};
          end
          ADDR_RESET:
          begin
            if (frameData[RESET_BIT])
            begin
              n.ctrl = CTRL_RESET;
              n.dataReg = CODE_ZERO;
              n.code = CODE_ZERO;
            end
          end
          default:
          begin
            // unknown address: frame ignored
          end
        endcase
      end
      // short frames are ignored as corrupt; long frames act on their last 24 bits
    end
    // clear holds the code every cycle it is high; code is not
    // touched on release, so the cleared value stays
    if (clearS)
    begin
      n.code = dfc_default_code(curRange, effSel);
    end
    // outputs stay off unless enabled; range picks which one
    n.voltEn = n.ctrl[CTRL_DRIVE_EN]
      & ~n.ctrl[CTRL_RANGE_HI];
    n.currEn = n.ctrl[CTRL_DRIVE_EN] & n.ctrl[CTRL_RANGE_HI]
      & (n.ctrl[CTRL_RANGE_HI:CTRL_RANGE_LO] != RANGE_BAD);
    // live fault levels; no latching, so the wire follows cause
    n.alertOe = headroomS | overTempS;
    n.status[STAT_CURR_FAULT] = headroomS;
    n.status[STAT_SLEW] = slewS;
    n.status[STAT_OVER_TEMP] = overTempS;
  end

  // ************************************************
  // state register
  // ************************************************
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      q <= '{sclkPrev: 1'b0, latchPrev: 1'b1, shift: '0,
        bitCnt: '0, ctrl: CTRL_RESET, dataReg: CODE_ZERO,
        code: CODE_ZERO, sdoShift: '0, voltEn: 1'b0,
        currEn: 1'b0, alertOe: 1'b0, status: '0};
    end
    else
    begin
      q <= n;
    end
  end

  // ************************************************
  // outputs, all but the constant alertOut straight from the state register
  // ************************************************
  assign link.sdo = q.sdoShift[15];
  assign link.alertOut = 1'b0; // open drain: only ever pulls low
  assign link.alertOe = q.alertOe;
  assign dacCode = q.code;
  assign rangeSel = q.ctrl[CTRL_RANGE_HI:CTRL_RANGE_LO];
  assign voltEnable = q.voltEn;
  assign currEnable = q.currEn;
  // modem signal rides the current output only when it is live
  assign modemCouplingEnable = q.currEn;
  assign rangeExtend = q.ctrl[CTRL_RANGE_EXTEND];
  assign outsideResistorSelect = q.ctrl[CTRL_OUTSIDE_RES];
  assign slewEnable = q.ctrl[CTRL_SR_EN];
  assign slewClock = q.ctrl[CTRL_SR_CLK_HI:CTRL_SR_CLK_LO];
  assign slewStep = q.ctrl[CTRL_SR_STEP_HI:CTRL_SR_STEP_LO];
  assign chainEnable = q.ctrl[CTRL_CHAIN_EN];
endmodule : dfc_device

// ==== dfc_host.sv ====
module dfc_host
  import dfc_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // link to the device
  dfc_link_if.host link
);
  // ************************************************
  // state
  // ************************************************
  typedef enum logic [2:0] {IDLE, BIT_LOW, BIT_HIGH, STROBE, GAP} dfc_host_e;

  typedef struct packed {
    dfc_host_e state; // frame sequencer
    logic [TIMER_W-1:0] timer; // half-bit countdown
    logic [CNT_W-1:0] bitIdx; // bits sent
    logic [FRAME_BITS-1:0] frame; // outgoing bits, MSB first
    logic [FRAME_BITS-1:0] capture; // incoming readback
    logic [15:0] readData; // last completed readback
    logic sclk;
    logic sdin;
    logic latchN;
    logic clearPin;
    logic clearSel;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } dfc_host_s;

  dfc_host_s q; // registered state
  dfc_host_s n; // next state
  logic [1:0] syncOut; // synced sdo and alert
  logic tick; // half bit elapsed
  logic busy; // frame in progress
  logic wrEn; // apb write completes
  logic setup; // apb setup cycle
  logic mapped; // address decodes

  // device side wires are pins here, so they are synchronised
  dfc_sync #(
    .WIDTH(2),
    .INIT(2'h2)
  ) uSync (
    .clock(clock),
    .rst_b(rst_b),
    .async({link.alertLine, link.sdo}),
    .sync(syncOut)
  );

  assign tick = (q.timer == '0);
  assign busy = (q.state != IDLE);
  assign setup = psel & ~penable;
  assign wrEn = psel & penable & pwrite & q.pready;
  assign mapped = (paddr == HOST_CMD) || (paddr == HOST_STATUS)
    || (paddr == HOST_PINS) || (paddr == HOST_RDATA);

  // ************************************************
  // next state
  // ************************************************
  // apb side answers with zero wait states; read data is
  // registered in the setup cycle so prdata leaves a flop
  always_comb
  begin
    n = q;
    n.pready = 1'b1;
    if (setup)
    begin
      n.pslverr = ~mapped;
      case (paddr)
        HOST_STATUS: n.prdata = {30'h0, syncOut[1] == 1'b0, busy};
        HOST_PINS: n.prdata = {30'h0, q.clearSel, q.clearPin};
        HOST_RDATA: n.prdata = {16'h0000, q.readData};
        default: n.prdata = 32'h0000_0000;
      endcase
    end
    // pins register: the host alone decides clear width
    if (wrEn && (paddr == HOST_PINS))
    begin
      n.clearPin = pwdata[PIN_CLEAR];
      n.clearSel = pwdata[PIN_CLEAR_SEL];
    end
    if (!tick)
    begin
      n.timer = q.timer - TIMER_W'(1);
    end
    case (q.state)
      IDLE:
      begin
        // commands while busy are dropped; poll busy first
        if (wrEn && (paddr == HOST_CMD))
        begin
          n.frame = pwdata[FRAME_BITS-1:0];
          n.sdin = pwdata[FRAME_BITS-1];
          n.bitIdx = '0;
          n.latchN = 1'b0;
          n.timer = TIMER_W'(SCLK_HALF - 1);
          // bare strobe restores the pre-clear value
          n.state = pwdata[CMD_LOAD_ONLY] ? STROBE : BIT_LOW;
        end
      end
      BIT_LOW:
      begin
        if (tick)
        begin
          n.sclk = 1'b1;
          n.capture = {q.capture[FRAME_BITS-2:0], syncOut[0]};
          n.timer = TIMER_W'(SCLK_HALF - 1);
          n.state = BIT_HIGH;
        end
      end
      BIT_HIGH:
      begin
        if (tick)
        begin
          n.sclk = 1'b0;
          n.frame = {q.frame[FRAME_BITS-2:0], 1'b0};
          n.sdin = q.frame[FRAME_BITS-2];
          n.bitIdx = q.bitIdx + CNT_W'(1);
          n.timer = TIMER_W'(SCLK_HALF - 1);
          n.state = (q.bitIdx == CNT_W'(FRAME_BITS - 1)) ? STROBE : BIT_LOW;
        end
      end
      STROBE:
      begin
        if (tick)
        begin
          n.latchN = 1'b1;
          n.timer = TIMER_W'(SCLK_HALF - 1);
          n.state = GAP;
        end
      end
      GAP:
      begin
        if (tick)
        begin
          n.readData = q.capture[FRAME_BITS-1:8];
          n.state = IDLE;
        end
      end
      default:
      begin
        n.state = IDLE;
      end
    endcase
  end

  // ************************************************
  // state register
  // ************************************************
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      q <= '{state: IDLE, timer: '0, bitIdx: '0, frame: '0,
        capture: '0, readData: 16'h0000, sclk: 1'b0, sdin: 1'b0,
        latchN: 1'b1, clearPin: 1'b0, clearSel: 1'b0,
        prdata: 32'h0000_0000, pready: 1'b0, pslverr: 1'b0};
    end
    else
    begin
      q <= n;
    end
  end

  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign link.sclk = q.sclk;
  assign link.sdin = q.sdin;
  assign link.latchN = q.latchN;
  assign link.clearPin = q.clearPin;
  assign link.clearSelPin = q.clearSel;
endmodule : dfc_host

// ==== dfc_link_if.sv ====
// ************************************************
// serial link, clear pins and shared alert wire
// ************************************************
interface dfc_link_if;
  logic sclk; // serial clock from host
  logic sdin; // serial data to device
  logic latchN; // load strobe, active low
  logic sdo; // serial readback from device
  logic clearPin; // asynchronous clear, active high
  logic clearSelPin; // clear level select pin
  logic alertOut; // open-drain data, always low
  logic alertOe; // high while device pulls the wire
  logic alertLine; // resolved wire with pull-up
  // pull-up wins unless the device pulls low
  assign alertLine = alertOe ? alertOut : 1'b1;
  modport device(
    input sclk, sdin, latchN, clearPin, clearSelPin,
    output sdo, alertOut, alertOe
  );
  modport host(
    output sclk, sdin, latchN, clearPin, clearSelPin,
    input sdo, alertLine
  );
endinterface : dfc_link_if

// ==== dfc_pkg.sv ====
package dfc_pkg;
  // ************************************************
  // timing
  // ************************************************
  localparam int CLK_HZ = 20_000_000; // system clock rate
  localparam int SCLK_HZ = 1_250_000; // serial bit rate chosen for the link
  localparam int SCLK_HALF = CLK_HZ / (2 * SCLK_HZ); // cycles per half bit
  localparam int TIMER_W = 8; // wide enough for SCLK_HALF
  // ************************************************
  // serial frame
  // ************************************************
  localparam int FRAME_BITS = 24; // address byte plus data word
  localparam int CNT_W = 5; // bit counter, saturates at FRAME_BITS
  localparam logic [7:0] ADDR_DATA = 8'h01; // output value
  localparam logic [7:0] ADDR_READ = 8'h02; // status readback request
  localparam logic [7:0] ADDR_CTRL = 8'h55; // control word
  localparam logic [7:0] ADDR_RESET = 8'h56; // soft reset
  localparam int RESET_BIT = 0; // reset request bit of the data word
  // ************************************************
  // control word fields
  // ************************************************
  localparam int CTRL_CLEAR_LEVEL = 15; // clear_level_bit
  localparam int CTRL_RANGE_EXTEND = 14; // range_extend_bit
  localparam int CTRL_OUTSIDE_RES = 13; // outside_resistor_select
  localparam int CTRL_DRIVE_EN = 12; // output_drive_enable
  localparam int CTRL_SR_CLK_HI = 11; // slew update clock field
  localparam int CTRL_SR_CLK_LO = 8;
  localparam int CTRL_SR_STEP_HI = 7; // slew step field
  localparam int CTRL_SR_STEP_LO = 5;
  localparam int CTRL_SR_EN = 4; // slew enable
  localparam int CTRL_CHAIN_EN = 3; // daisy chain enable
  localparam int CTRL_RANGE_HI = 2; // range select
  localparam int CTRL_RANGE_LO = 0;
  localparam logic [15:0] CTRL_RESET = 16'h0000; // power-on control word
  localparam logic [2:0] RANGE_PM5 = 3'h2; // bipolar 5 V
  localparam logic [2:0] RANGE_PM10 = 3'h3; // bipolar 10 V
  localparam logic [2:0] RANGE_BAD = 3'h4; // unused code, no output
  // ************************************************
  // status word and codes
  // ************************************************
  localparam int STAT_CURR_FAULT = 2; // current output headroom fault
  localparam int STAT_SLEW = 1; // slew in progress
  localparam int STAT_OVER_TEMP = 0; // die over temperature
  localparam logic [15:0] CODE_ZERO = 16'h0000; // lowest code
  localparam logic [15:0] CODE_MID = 16'h8000; // midscale code
  // ************************************************
  // host register map (byte addresses)
  // ************************************************
  localparam logic [31:0] HOST_CMD = 32'h0000_0000; // frame to send
  localparam logic [31:0] HOST_STATUS = 32'h0000_0004; // busy, alert
  localparam logic [31:0] HOST_PINS = 32'h0000_0008; // clear pins
  localparam logic [31:0] HOST_RDATA = 32'h0000_000C; // last readback
  localparam int CMD_LOAD_ONLY = 24; // latch pulse without data
  localparam int HST_BUSY = 0;
  localparam int HST_ALERT = 1;
  localparam int PIN_CLEAR = 0;
  localparam int PIN_CLEAR_SEL = 1;

  // clear / default code for a range and clear-level selection
  function automatic logic [15:0] dfc_default_code(
    input logic [2:0] range,
    input logic sel
  );
    logic bip;
    bip = (range == RANGE_PM5) || (range == RANGE_PM10);
    if (range[2])
    begin
      return CODE_ZERO; // current ranges go to the bottom
    end
    else if (bip)
    begin
      return sel ? CODE_ZERO : CODE_MID; // offset binary: mid is 0 V
    end
    return sel ? CODE_MID : CODE_ZERO;
  endfunction : dfc_default_code
endpackage : dfc_pkg

// ==== dfc_sync.sv ====
// ************************************************
// two-stage synchroniser for a bundle of levels
// ************************************************
module dfc_sync
  import dfc_pkg::*;
#(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
)
(
  // clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // levels
  input wire logic [WIDTH-1:0] async,
  output logic [WIDTH-1:0] sync
);
  logic [WIDTH-1:0] meta_q; // first stage, read only by second

  // both stages reset to the idle level of each input
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      meta_q <= INIT;
      sync <= INIT;
    end
    else
    begin
      meta_q <= async;
      sync <= meta_q;
    end
  end
endmodule : dfc_sync

// ==== tb.sv ====
module tb
  import dfc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // ********
  // signals
  // ********
  logic clock, rst_b, psel, penable, pwrite, pready, pslverr, serr;
  logic [31:0] paddr, pwdata, prdata, r;
  logic headroomLow, overTemp, voltEnable, currEnable, modemEn, rngExt;
  logic resSel, slewBusy, slewEn, chainEn;
  logic [2:0] rangeSel, slewStp;
  logic [3:0] slewClk;
  logic [15:0] dacCode, ens, ctlOut;
  int n_fail, checks_done;
  // enables packed into one word for compact compares
  assign ens = {11'h0, voltEnable, currEnable, modemEn, rngExt, resSel};
  // range and slew settings packed the same way
  assign ctlOut = {4'h0, rangeSel, slewClk, slewStp, slewEn, chainEn};
  dfc_link_if link();
  dfc_host i_dfc_host(.clock(clock), .rst_b(rst_b), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link));
  dfc_device i_dfc_device(.clock(clock), .rst_b(rst_b), .link(link),
    .headroomLow(headroomLow), .overTemp(overTemp), .slewBusy(slewBusy),
    .dacCode(dacCode), .rangeSel(rangeSel), .voltEnable(voltEnable),
    .currEnable(currEnable), .modemCouplingEnable(modemEn),
    .rangeExtend(rngExt), .outsideResistorSelect(resSel),
    .slewEnable(slewEn), .slewClock(slewClk), .slewStep(slewStp),
    .chainEnable(chainEn));
  dfc_chk i_chk(.clock(clock), .rst_b(rst_b), .sclk(link.sclk),
    .sdin(link.sdin), .latchN(link.latchN), .alertOut(link.alertOut),
    .alertOe(link.alertOe), .headroomLow(headroomLow),
    .overTemp(overTemp));
  // ********
  // tasks
  // ********
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    checks_done++;
    if (s !== e)
    begin
      n_fail++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report
  // one apb transfer; read data and error land in r and serr
  task automatic apb(input logic w, input logic [31:0] a,
    input logic [31:0] d);
    int n;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    r = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1)
    begin
      n_fail++;
      final_report();
    end
  endtask : apb
  // frame out, then poll busy; a frame is about 400 cycles
  task automatic send(input logic [31:0] w);
    int n;
    apb(1'b1, HOST_CMD, w);
    repeat (4) @(posedge clock);
    n = 0;
    do
    begin
      apb(1'b0, HOST_STATUS, 32'h0);
      n++;
    end
    while (r[HST_BUSY] !== 1'b0 && n < 300);
    if (r[HST_BUSY] !== 1'b0)
    begin
      n_fail++;
      final_report();
    end
    repeat (4) @(posedge clock);
  endtask : send
  // pins pass a two-stage sync, so leave margin
  task automatic pins(input logic [1:0] p);
    apb(1'b1, HOST_PINS, {30'h0, p});
    repeat (8) @(posedge clock);
  endtask : pins
  // status frame, then a dummy frame to shift the answer out
  task automatic rb(input logic [15:0] e);
    send(32'h0002_0000);
    send(32'h0000_0000);
    apb(1'b0, HOST_RDATA, 32'h0);
    chk(r[15:0], e);
  endtask : rb
  initial
  begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  // ********
  // main sequence
  // ********
  initial
  begin
    {rst_b, psel, penable, pwrite, headroomLow, overTemp, slewBusy} = '0;
    paddr = '0;
    pwdata = '0;
    n_fail = 0;
    checks_done = 0;
    repeat (8) @(posedge clock);
    rst_b <= 1'b1;
    repeat (2) @(posedge clock);
    chk(ens, 16'h0000);
    chk({15'h0, link.alertLine}, 16'h0001);
    // enable with clear level set on a unipolar range
    send(32'h0055_F000);
    chk(dacCode, CODE_MID);
    chk(ens, 16'h0013);
    send(32'h0001_1234);
    chk(dacCode, 16'h1234);
    send(32'h0055_7003);
    chk(dacCode, CODE_MID);
    send(32'h0001_4321);
    pins(2'b01);
    chk(dacCode, CODE_MID);
    pins(2'b11);
    chk(dacCode, CODE_ZERO);
    send(32'h0001_5555);
    chk(dacCode, CODE_ZERO);
    pins(2'b00);
    chk(dacCode, CODE_ZERO);
    send(32'h0100_0000);
    chk(dacCode, 16'h4321);
    send(32'h0055_7005);
    chk(dacCode, CODE_ZERO);
    chk(ens, 16'h000F);
    send(32'h0001_2222);
    pins(2'b01);
    chk(dacCode, CODE_ZERO);
    pins(2'b00);
    send(32'h0055_0005);
    chk(ens, 16'h0000);
    // slew limiting goes on with the modem path; output was off first
    send(32'h0055_1BFE);
    chk(ctlOut, 16'h0D7F);
    chk(ens, 16'h000C);
    chk(dacCode, CODE_ZERO);
    // unused range code drives neither output
    send(32'h0055_1004);
    chk(ens, 16'h0000);
    chk(ctlOut, 16'h0800);
    // alert causes one at a time
    headroomLow <= 1'b1;
    repeat (8) @(posedge clock);
    chk({15'h0, link.alertLine}, 16'h0000);
    rb(16'h0004);
    headroomLow <= 1'b0;
    overTemp <= 1'b1;
    slewBusy <= 1'b1;
    rb(16'h0003);
    apb(1'b1, HOST_STATUS, 32'h0000_FFFF);
    apb(1'b0, HOST_STATUS, 32'h0);
    chk({14'h0, r[1:0]}, 16'h0002);
    overTemp <= 1'b0;
    slewBusy <= 1'b0;
    repeat (8) @(posedge clock);
    chk({15'h0, link.alertLine}, 16'h0001);
    apb(1'b0, 32'h0000_0010, 32'h0);
    chk({15'h0, serr}, 16'h0001);
    final_report();
  end
endmodule : tb
